// File: logic/irq_level_pkg.sv
// Purpose: Shared constants for the interrupt source level configuration bank.
// Assumes: APB slave with 32-bit data, one 16-bit register per aligned word.
// Notes: Register offsets are word indices; byte address is four times the index.
package irq_level_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus and field geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int FIELD_W = 2;
  localparam int NUM_REGS = 4;
  localparam int NUM_SRC = 25;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 4;

  // Register indices as printed (byte address = index * 4)
  localparam logic [IDX_W-1:0] IDX_DECODER_CFG = 4'h6;
  localparam logic [IDX_W-1:0] IDX_TIMER_AB_C = 4'h7;
  localparam logic [IDX_W-1:0] IDX_SERIAL0_TIMER_A = 4'h8;
  localparam logic [IDX_W-1:0] IDX_PWM_CONVERTER = 4'h9;

  // Writable bit masks; zero bits are reserved, read zero, ignore writes
  localparam logic [REG_W-1:0] MASK_DECODER_CFG = 16'h000F;
  localparam logic [REG_W-1:0] MASK_TIMER_AB_C = 16'hFFFF;
  localparam logic [REG_W-1:0] MASK_SERIAL0_TIMER_A = 16'hF3FF;
  localparam logic [REG_W-1:0] MASK_PWM_CONVERTER = 16'hFFFF;
  localparam logic [REG_W-1:0] CFG_RESET = 16'h0000;

  // Field encodings
  localparam logic [FIELD_W-1:0] FIELD_DISABLED = 2'h0;
  localparam logic [FIELD_W-1:0] FIELD_TOP = 2'h3;
  localparam logic [FIELD_W-1:0] LEVEL_MAX = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Source table: bank slot (0..3 for indices 6..9) and field LSB per source.
  // Order: decoder0_index, decoder0_home_wdog, timer_a_ch0, timer_b_ch3..ch0,
  // timer_c_ch3..ch1, serial0_rx_full, serial0_rx_error, serial0_tx_idle,
  // serial0_tx_empty, timer_a_ch3..ch1, pwm_unit_a_fault, pwm_unit_b_fault,
  // pwm_unit_a_reload, pwm_unit_b_reload, converter_a_zero_cross,
  // converter_b_zero_cross, converter_a_done, converter_b_done.
  localparam int SRC_SLOT [NUM_SRC] = '{
    0, 0,
    1, 1, 1, 1, 1, 1, 1, 1,
    2, 2, 2, 2, 2, 2, 2,
    3, 3, 3, 3, 3, 3, 3, 3
  };
  localparam int SRC_LSB [NUM_SRC] = '{
    2, 0,
    14, 12, 10, 8, 6, 4, 2, 0,
    14, 12, 8, 6, 4, 2, 0,
    14, 12, 10, 8, 6, 4, 2, 0
  };

endpackage

// File: logic/irq_level_regs.sv
// Purpose: APB bank of interrupt source level fields feeding the priority resolver.
// Assumes: APB4 master on pclk; resolver samples enables and levels each cycle.
// Notes: Always ready; unmapped or misaligned access answers with pslverr.
module irq_level_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [irq_level_pkg::ADDR_W-1:0] paddr,
  input wire logic [irq_level_pkg::DATA_W-1:0] pwdata,
  input wire logic [irq_level_pkg::DATA_W/8-1:0] pstrb,
  output logic [irq_level_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // To priority resolver, one bit / one field per source
  output logic [irq_level_pkg::NUM_SRC-1:0] src_enable,
  output logic [irq_level_pkg::NUM_SRC*irq_level_pkg::FIELD_W-1:0] src_level
);

  localparam int RW = irq_level_pkg::REG_W;
  localparam int FW = irq_level_pkg::FIELD_W;
  localparam int NR = irq_level_pkg::NUM_REGS;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic [irq_level_pkg::IDX_W-1:0] word_idx;
  logic upper_zero;
  logic aligned;
  logic [NR-1:0] hit;
  logic any_hit;
  logic access;
  logic setup_read;
  logic [NR-1:0] wr_en;
  logic [RW-1:0] cfg [NR];
  logic [RW-1:0] rd_word;
  logic [irq_level_pkg::DATA_W-1:0] prdata_q;
  logic [irq_level_pkg::DATA_W-1:0] prdata_d;

  // Word index from byte address
  assign word_idx = paddr[irq_level_pkg::IDX_LSB +: irq_level_pkg::IDX_W];
  assign upper_zero = (paddr[irq_level_pkg::ADDR_W-1:irq_level_pkg::IDX_LSB+irq_level_pkg::IDX_W]
                       == '0);
  assign aligned = (paddr[irq_level_pkg::IDX_LSB-1:0] == '0);
  assign hit[0] = upper_zero && aligned && (word_idx == irq_level_pkg::IDX_DECODER_CFG);
  assign hit[1] = upper_zero && aligned && (word_idx == irq_level_pkg::IDX_TIMER_AB_C);
  assign hit[2] = upper_zero && aligned && (word_idx == irq_level_pkg::IDX_SERIAL0_TIMER_A);
  assign hit[3] = upper_zero && aligned && (word_idx == irq_level_pkg::IDX_PWM_CONVERTER);
  assign any_hit = |hit;

  // Phase qualifiers
  assign access = psel && penable;
  assign setup_read = psel && !penable && !pwrite;
  assign wr_en = (access && pwrite) ? hit : '0;

  // Zero-wait slave; error on unmapped or misaligned access
  assign pready = 1'b1;
  assign pslverr = access && !any_hit;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Decoder0 index and home/watchdog fields, upper bits reserved
  level_cfg_reg #(
    .WIDTH(RW),
    .WMASK(irq_level_pkg::MASK_DECODER_CFG),
    .RESET(irq_level_pkg::CFG_RESET)
  ) u_reg_decoder (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_en[0]),
    .wdata(pwdata[RW-1:0]),
    .wstrb(pstrb[RW/8-1:0]),
    .value_q(cfg[0])
  );

  // Timer A ch0 and timer B fields
  // Timer C fields in low bits
  level_cfg_reg #(
    .WIDTH(RW),
    .WMASK(irq_level_pkg::MASK_TIMER_AB_C),
    .RESET(irq_level_pkg::CFG_RESET)
  ) u_reg_timer_abc (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_en[1]),
    .wdata(pwdata[RW-1:0]),
    .wstrb(pstrb[RW/8-1:0]),
    .value_q(cfg[1])
  );

  // Bits 11-10 masked off, read zero
  level_cfg_reg #(
    .WIDTH(RW),
    .WMASK(irq_level_pkg::MASK_SERIAL0_TIMER_A),
    .RESET(irq_level_pkg::CFG_RESET)
  ) u_reg_serial0 (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_en[2]),
    .wdata(pwdata[RW-1:0]),
    .wstrb(pstrb[RW/8-1:0]),
    .value_q(cfg[2])
  );

  level_cfg_reg #(
    .WIDTH(RW),
    .WMASK(irq_level_pkg::MASK_PWM_CONVERTER),
    .RESET(irq_level_pkg::CFG_RESET)
  ) u_reg_pwm_conv (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_en[3]),
    .wdata(pwdata[RW-1:0]),
    .wstrb(pstrb[RW/8-1:0]),
    .value_q(cfg[3])
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Read path

  // Select addressed word, zero when unmapped
  assign rd_word = hit[0] ? cfg[0] :
                   hit[1] ? cfg[1] :
                   hit[2] ? cfg[2] :
                   hit[3] ? cfg[3] : '0;
  assign prdata_d = {{(irq_level_pkg::DATA_W-RW){1'b0}}, rd_word};

  // Capture read data in setup so it stands through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (setup_read) begin
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Named source fields

  // Port positions of the sources toward the resolver
  // Order matches the source table of the package
  // Decoder0 register
  localparam int DECODER0_INDEX_SRC = 0;
  localparam int DECODER0_HOME_WDOG_SRC = 1;

  // Timer A/B/C register
  localparam int TIMER_A_CH0_SRC = 2;
  localparam int TIMER_B_CH3_SRC = 3;
  localparam int TIMER_B_CH2_SRC = 4;
  localparam int TIMER_B_CH1_SRC = 5;
  localparam int TIMER_B_CH0_SRC = 6;
  localparam int TIMER_C_CH3_SRC = 7;
  localparam int TIMER_C_CH2_SRC = 8;
  localparam int TIMER_C_CH1_SRC = 9;

  // Serial0 and timer A register
  localparam int SERIAL0_RX_FULL_SRC = 10;
  localparam int SERIAL0_RX_ERROR_SRC = 11;
  localparam int SERIAL0_TX_IDLE_SRC = 12;
  localparam int SERIAL0_TX_EMPTY_SRC = 13;
  localparam int TIMER_A_CH3_SRC = 14;
  localparam int TIMER_A_CH2_SRC = 15;
  localparam int TIMER_A_CH1_SRC = 16;

  // PWM and converter register
  localparam int PWM_UNIT_A_FAULT_SRC = 17;
  localparam int PWM_UNIT_B_FAULT_SRC = 18;
  localparam int PWM_UNIT_A_RELOAD_SRC = 19;
  localparam int PWM_UNIT_B_RELOAD_SRC = 20;
  localparam int CONVERTER_A_ZERO_CROSS_SRC = 21;
  localparam int CONVERTER_B_ZERO_CROSS_SRC = 22;
  localparam int CONVERTER_A_DONE_SRC = 23;
  localparam int CONVERTER_B_DONE_SRC = 24;

  // Field slices, one per source, taken through the source table
  logic [FW-1:0] field_of [irq_level_pkg::NUM_SRC];

  // Slice each source field out of its register
  genvar f;
  generate
    for (f = 0; f < irq_level_pkg::NUM_SRC; f++) begin : g_field
      assign field_of[f] = cfg[irq_level_pkg::SRC_SLOT[f]][irq_level_pkg::SRC_LSB[f] +: FW];
    end
  endgenerate

  // Named fields, readable in waves and in the hand-off below
  logic [FW-1:0] decoder0_index_level;
  logic [FW-1:0] decoder0_home_wdog_level;
  logic [FW-1:0] timer_a_ch0_level;
  logic [FW-1:0] timer_b_ch3_level;
  logic [FW-1:0] timer_b_ch2_level;
  logic [FW-1:0] timer_b_ch1_level;
  logic [FW-1:0] timer_b_ch0_level;
  logic [FW-1:0] timer_c_ch3_level;
  logic [FW-1:0] timer_c_ch2_level;
  logic [FW-1:0] timer_c_ch1_level;
  logic [FW-1:0] serial0_rx_full_level;
  logic [FW-1:0] serial0_rx_error_level;
  logic [FW-1:0] serial0_tx_idle_level;
  logic [FW-1:0] serial0_tx_empty_level;
  logic [FW-1:0] timer_a_ch3_level;
  logic [FW-1:0] timer_a_ch2_level;
  logic [FW-1:0] timer_a_ch1_level;
  logic [FW-1:0] pwm_unit_a_fault_level;
  logic [FW-1:0] pwm_unit_b_fault_level;
  logic [FW-1:0] pwm_unit_a_reload_level;
  logic [FW-1:0] pwm_unit_b_reload_level;
  logic [FW-1:0] converter_a_zero_cross_level;
  logic [FW-1:0] converter_b_zero_cross_level;
  logic [FW-1:0] converter_a_done_level;
  logic [FW-1:0] converter_b_done_level;

  assign decoder0_index_level = field_of[DECODER0_INDEX_SRC];
  assign decoder0_home_wdog_level = field_of[DECODER0_HOME_WDOG_SRC];

  // Timer A ch0 on top, timer B ch3 down to ch0
  assign timer_a_ch0_level = field_of[TIMER_A_CH0_SRC];
  assign timer_b_ch3_level = field_of[TIMER_B_CH3_SRC];
  assign timer_b_ch2_level = field_of[TIMER_B_CH2_SRC];
  assign timer_b_ch1_level = field_of[TIMER_B_CH1_SRC];
  assign timer_b_ch0_level = field_of[TIMER_B_CH0_SRC];

  // Timer C ch3 down to ch1 in the low bits
  assign timer_c_ch3_level = field_of[TIMER_C_CH3_SRC];
  assign timer_c_ch2_level = field_of[TIMER_C_CH2_SRC];
  assign timer_c_ch1_level = field_of[TIMER_C_CH1_SRC];

  // Serial0 sources around the reserved pair
  assign serial0_rx_full_level = field_of[SERIAL0_RX_FULL_SRC];
  assign serial0_rx_error_level = field_of[SERIAL0_RX_ERROR_SRC];
  assign serial0_tx_idle_level = field_of[SERIAL0_TX_IDLE_SRC];
  assign serial0_tx_empty_level = field_of[SERIAL0_TX_EMPTY_SRC];

  // Timer A ch3 down to ch1
  assign timer_a_ch3_level = field_of[TIMER_A_CH3_SRC];
  assign timer_a_ch2_level = field_of[TIMER_A_CH2_SRC];
  assign timer_a_ch1_level = field_of[TIMER_A_CH1_SRC];

  assign pwm_unit_a_fault_level = field_of[PWM_UNIT_A_FAULT_SRC];
  assign pwm_unit_b_fault_level = field_of[PWM_UNIT_B_FAULT_SRC];
  assign pwm_unit_a_reload_level = field_of[PWM_UNIT_A_RELOAD_SRC];
  assign pwm_unit_b_reload_level = field_of[PWM_UNIT_B_RELOAD_SRC];

  // Converter zero-cross and done in the low byte
  assign converter_a_zero_cross_level = field_of[CONVERTER_A_ZERO_CROSS_SRC];
  assign converter_b_zero_cross_level = field_of[CONVERTER_B_ZERO_CROSS_SRC];
  assign converter_a_done_level = field_of[CONVERTER_A_DONE_SRC];
  assign converter_b_done_level = field_of[CONVERTER_B_DONE_SRC];

  // Packed hand-off, source s at bits [s*FW +: FW]
  logic [irq_level_pkg::NUM_SRC*FW-1:0] field_vec;

  assign field_vec = {
    converter_b_done_level,
    converter_a_done_level,
    converter_b_zero_cross_level,
    converter_a_zero_cross_level,
    pwm_unit_b_reload_level,
    pwm_unit_a_reload_level,
    pwm_unit_b_fault_level,
    pwm_unit_a_fault_level,
    timer_a_ch1_level,
    timer_a_ch2_level,
    timer_a_ch3_level,
    serial0_tx_empty_level,
    serial0_tx_idle_level,
    serial0_rx_error_level,
    serial0_rx_full_level,
    timer_c_ch1_level,
    timer_c_ch2_level,
    timer_c_ch3_level,
    timer_b_ch0_level,
    timer_b_ch1_level,
    timer_b_ch2_level,
    timer_b_ch3_level,
    timer_a_ch0_level,
    decoder0_home_wdog_level,
    decoder0_index_level
  };

  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // Refuse package values that the bank layout cannot serve
  if (irq_level_pkg::DATA_W < RW) begin : g_chk_data_w
    $error("irq_level_regs: data bus narrower than one register");
  end
  if (irq_level_pkg::IDX_LSB + irq_level_pkg::IDX_W >= irq_level_pkg::ADDR_W) begin : g_chk_addr
    $error("irq_level_regs: word index does not fit the address");
  end
  if (RW % FW != 0) begin : g_chk_field
    $error("irq_level_regs: fields do not tile a register");
  end
  if (FW != $bits(irq_level_pkg::FIELD_DISABLED)) begin : g_chk_code
    $error("irq_level_regs: field width differs from the code width");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-source decode toward the resolver

  // One decoder per source
  genvar s;
  generate
    for (s = 0; s < irq_level_pkg::NUM_SRC; s++) begin : g_src
      // Top code maps to level 2
      level_decode #(
        .FIELD_W(FW)
      ) u_dec (
        .pclk(pclk),
        .presetn(presetn),
        .field(field_vec[s*FW +: FW]),
        .enable_q(src_enable[s]),
        .level_q(src_level[s*FW +: FW])
      );
    end
  endgenerate

endmodule

// File: logic/level_cfg_reg.sv
// Purpose: One 16-bit level configuration register with byte strobes.
// Assumes: Write enable is a single-cycle pulse at the APB access edge.
// Notes: Reserved bits are never stored, so they always read zero.
module level_cfg_reg #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] WMASK = '1,
  parameter logic [WIDTH-1:0] RESET = '0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Write port
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [WIDTH/8-1:0] wstrb,
  // Stored value
  output logic [WIDTH-1:0] value_q
);

  logic [WIDTH-1:0] lane_mask;
  logic [WIDTH-1:0] value_d;

  initial begin
    if (WIDTH % 8 != 0) $error("level_cfg_reg: WIDTH must be whole bytes");
  end

  // Expand byte strobes to bits
  genvar b;
  generate
    for (b = 0; b < WIDTH/8; b++) begin : g_lane
      assign lane_mask[b*8 +: 8] = {8{wstrb[b]}};
    end
  endgenerate

  // Merge only writable bits of enabled lanes
  assign value_d = (value_q & ~(lane_mask & WMASK)) | (wdata & lane_mask & WMASK);

  // Storage, disabled pattern after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_q <= RESET;
    end else if (wr_en) begin
      value_q <= value_d;
    end
  end

endmodule

// File: logic/level_decode.sv
// Purpose: Decode one two-bit source field into enable and level.
// Assumes: Field comes straight from a configuration register.
// Notes: Outputs are registered; they follow the field one cycle later.
module level_decode #(
  parameter int FIELD_W = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Field from register
  input wire logic [FIELD_W-1:0] field,
  // To priority resolver
  output logic enable_q,
  output logic [FIELD_W-1:0] level_q
);

  logic enable_d;
  logic [FIELD_W-1:0] level_d;

  initial begin
    if (FIELD_W != 2) $error("level_decode: only two-bit fields supported");
  end

  // Zero disables; otherwise level is the code minus one
  assign enable_d = (field != irq_level_pkg::FIELD_DISABLED);
  assign level_d = enable_d ? FIELD_W'(field - 1'b1) : irq_level_pkg::FIELD_DISABLED;

  // Registered outputs, disabled out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= 1'b0;
      level_q <= irq_level_pkg::FIELD_DISABLED;
    end else begin
      enable_q <= enable_d;
      level_q <= level_d;
    end
  end

endmodule

// File: tb/irq_level_regs_asserts.sv
// Purpose: Port checks for the level bank.
// Assumes: Bound onto irq_level_regs.
// Notes: One clock domain.
module irq_level_regs_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Resolver side
  input wire logic [24:0] src_enable,
  input wire logic [49:0] src_level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // Access decode and field scans
  wire acc = psel && penable;
  wire rd = acc && !pwrite;
  wire wr = acc && pwrite && pstrb[1];
  logic top, off;
  always_comb begin
    top = 1'b0;
    off = 1'b0;
    for (int i = 0; i < 25; i++) begin
      top = top | (src_level[2*i+:2] == 2'h3);
      off = off | (!src_enable[i] && src_level[2*i+:2] != 2'h0);
    end
  end
  ////////////////////////////////////////
  reset_clear_a: assert property ($rose(presetn) |-> src_enable == 25'h0)
    else $error("outputs not clear after reset");
  top_level_a: assert property (!top)
    else $error("level above 2");
  off_zero_a: assert property (!off)
    else $error("disabled source shows a level");
  wr_max_a: assert property (wr && paddr == 12'h01C && pwdata[15:14] == 2'h3
    |-> ##2 src_enable[2] && src_level[5:4] == 2'h2) else $error("timer A ch0 not level 2");
  wr_off_a: assert property (wr && paddr == 12'h01C && pwdata[15:14] == 2'h0
    |-> ##2 !src_enable[2]) else $error("timer A ch0 still on");
  pwm_reload_a: assert property (wr && paddr == 12'h024 && pwdata[11:10] == 2'h2
    |-> ##2 src_enable[19] && src_level[39:38] == 2'h1) else $error("pwm reload wrong");
  rsv_read_a: assert property (rd && paddr == 12'h020 |-> prdata[11:10] == 2'h0)
    else $error("reserved bits read nonzero");
  dec_read_a: assert property (rd && paddr == 12'h018 |-> prdata[15:4] == 12'h000)
    else $error("decoder register high bits nonzero");
  serial_idle_a: assert property (wr && paddr == 12'h020 && pwdata[9:8] == 2'h3
    |-> ##2 src_enable[12] && src_level[25:24] == 2'h2) else $error("serial0 tx idle wrong");
  conv_done_a: assert property (acc && pwrite && pstrb[0] && paddr == 12'h024
    && pwdata[1:0] == 2'h1 |-> ##2 src_enable[24] && src_level[49:48] == 2'h0)
    else $error("converter B done wrong");
  bus_answer_a: assert property (acc |-> pready && pslverr == !(paddr[1:0] == 2'h0
    && paddr >= 12'h018 && paddr <= 12'h024)) else $error("bus answer wrong");
  cover property (wr && paddr == 12'h01C);
  cover property (acc && pslverr);
  cover property (rd && paddr == 12'h020);
endmodule

bind irq_level_regs irq_level_regs_asserts chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_enable(src_enable),
  .src_level(src_level));

// File: tb/irq_level_regs_tb.sv
// Purpose: Self-checking bench for the level bank.
// Assumes: Zero wait APB slave.
// Notes: Outputs checked three edges after each batch of writes.
module irq_level_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, any_req;
  logic [24:0] src_enable;
  logic [49:0] src_level;
  logic [15:0] shadow [4];
  logic [15:0] wm [4] = '{16'h000F, 16'hFFFF, 16'hF3FF, 16'hFFFF};
  int lsb [25] = '{2, 0, 14, 12, 10, 8, 6, 4, 2, 0, 14, 12, 8, 6, 4, 2, 0,
    14, 12, 10, 8, 6, 4, 2, 0};
  int errors = 0;
  int total_checks = 0;
  logic [11:0] bad [3] = '{12'h028, 12'h01D, 12'h058};
  always #10 pclk = ~pclk;
  irq_level_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_enable(src_enable), .src_level(src_level));
  level_resolver_model res (.pclk(pclk), .presetn(presetn), .src_enable(src_enable),
    .any_req_q(any_req));
  ////////////////////////////////////////
  task automatic check(input logic [79:0] got, input logic [79:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One APB transfer, started one edge after entry
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      errors++;
      conclude();
    end else begin
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wr(input int i, input logic [15:0] d, input logic [3:0] s);
    logic [15:0] m;
    logic [31:0] r;
    logic e;
    m = {{8{s[1]}}, {8{s[0]}}} & wm[i];
    apb(12'h018 + 12'(4 * i), 1'b1, {16'($urandom), d}, s, r, e);
    check(e, 1'b0, "write error");
    shadow[i] = (shadow[i] & ~m) | (d & m);
  endtask
  // Expected enables and levels from the shadow copy
  function automatic logic [74:0] expect_out();
    logic [1:0] f;
    int k;
    expect_out = '0;
    for (int s = 0; s < 25; s++) begin
      k = (s < 2) ? 0 : (s < 10) ? 1 : (s < 17) ? 2 : 3;
      f = shadow[k][lsb[s]+:2];
      expect_out[50+s] = (f != 2'h0);
      expect_out[2*s+:2] = (f == 2'h0) ? 2'h0 : f - 2'h1;
    end
  endfunction
  task automatic verify();
    logic [74:0] x;
    logic [31:0] r;
    logic e;
    repeat (3) @(posedge pclk);
    x = expect_out();
    check({src_enable[1:0], src_level[3:0]}, {x[51:50], x[3:0]}, "decoder");
    check({src_enable[9:2], src_level[19:4]}, {x[59:52], x[19:4]}, "timers");
    check({src_enable[16:10], src_level[33:20]}, {x[66:60], x[33:20]}, "serial");
    check({src_enable[24:17], src_level[49:34]}, {x[74:67], x[49:34]}, "pwm");
    check(any_req, |x[74:50], "resolver");
    for (int i = 0; i < 4; i++) begin
      apb(12'h018 + 12'(4 * i), 1'b0, 32'h0, 4'h0, r, e);
      check({e, r}, {17'h0, shadow[i]}, "readback");
    end
  endtask
  ////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic e;
    r = $urandom(32'h5273);
    shadow = '{default: 16'h0};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    verify();
    for (int c = 0; c < 4; c++) begin
      for (int i = 0; i < 4; i++) wr(i, {8{2'(c)}}, 4'h3);
      verify();
    end
    repeat (40) begin
      wr($urandom_range(3), 16'($urandom), 4'($urandom));
      verify();
    end
    // Unmapped and misaligned accesses
    for (int k = 0; k < 3; k++) begin
      apb(bad[k], 1'b1, 32'hFFFF, 4'hF, r, e);
      check(e, 1'b1, "unmapped write");
      apb(bad[k], 1'b0, 32'h0, 4'h0, r, e);
      check({e, r}, {1'b1, 32'h0}, "unmapped read");
    end
    verify();
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    shadow = '{default: 16'h0};
    verify();
    conclude();
  end
endmodule

// File: tb/level_resolver_model.sv
// Purpose: Behavioural priority resolver fed by the bank.
// Assumes: Samples enables every cycle.
// Notes: Reports request presence only.
module level_resolver_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // From bank
  input wire logic [24:0] src_enable,
  // To core
  output logic any_req_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // Any enabled source raises a request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      any_req_q <= 1'b0;
    end else begin
      any_req_q <= |src_enable;
    end
  end
endmodule
